// [include/dmr_regs.vh]
// Field layout, codes and timing counts of the base mode register block
`ifndef DMR_REGS_VH
`define DMR_REGS_VH

// Mode register field positions on address pins
`define DMR_MODE_WIDTH 13
`define DMR_BL_MSB 2
`define DMR_BL_LSB 0
`define DMR_ORDER_BIT 3
`define DMR_CL_MSB 6
`define DMR_CL_LSB 4
`define DMR_TEST_BIT 7
`define DMR_DLL_RESET_BIT 8
`define DMR_WR_MSB 11
`define DMR_WR_LSB 9
`define DMR_PD_EXIT_BIT 12
`define DMR_MODE_RESET 13'h0000

// Field codes
`define DMR_BL_CODE_4 3'h2
`define DMR_BL_CODE_8 3'h3
`define DMR_CL_CODE_MIN 3'h3
`define DMR_CL_CODE_MAX 3'h6
`define DMR_WR_CODE_MIN 3'h1
`define DMR_WR_CODE_MAX 3'h5
`define DMR_BANK_MODE 2'h0

// Beat indices of the two burst lengths
`define DMR_LAST_BEAT_4 3'h3
`define DMR_LAST_BEAT_8 3'h7

// Clock cycles the DLL needs after a reset before reads are safe
`define DMR_DLL_LOCK_CYCLES 8'hC8

// Beat word: write flag, bank, column bits 9..3, column bits 2..0, last flag
`define DMR_BEAT_WIDTH 14
`define DMR_COL_WIDTH 10
`define DMR_BUF_DEPTH 2

`endif

// [hdl/dmr_beat_buffer.v]
// Two-entry valid/ready buffer holding burst beat words
`timescale 1ns/100ps
`default_nettype none
`include "dmr_regs.vh"

module dmr_beat_buffer (
   input wire clock,
   input wire nrst,
   input wire in_valid,
   input wire [`DMR_BEAT_WIDTH-1:0] in_data,
   output wire in_ready,
   output reg out_valid,
   output reg [`DMR_BEAT_WIDTH-1:0] out_data,
   input wire out_ready
);

   // Head feeds the output directly from a flip-flop; tail absorbs one stall
   reg [`DMR_BEAT_WIDTH-1:0] tail_data;
   reg tail_valid;
   wire push;
   wire pop;

   // Ready depends on the tail only, so a full buffer stalls the source
   assign in_ready = ~tail_valid;
   assign push = in_valid & ~tail_valid;
   assign pop = out_valid & out_ready;

   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         out_valid <= 1'b0;
         out_data <= {`DMR_BEAT_WIDTH{1'b0}};
         tail_valid <= 1'b0;
         tail_data <= {`DMR_BEAT_WIDTH{1'b0}};
      end
      else if (pop)
      begin
         if (tail_valid)
         begin
            out_data <= tail_data;
            out_valid <= 1'b1;
            tail_valid <= 1'b0;
         end
         else if (push)
         begin
            out_data <= in_data;
            out_valid <= 1'b1;
         end
         else
         begin
            out_valid <= 1'b0;
         end
      end
      else if (push)
      begin
         if (!out_valid)
         begin
            out_data <= in_data;
            out_valid <= 1'b1;
         end
         else
         begin
            tail_data <= in_data;
            tail_valid <= 1'b1;
         end
      end
   end

endmodule // dmr_beat_buffer

`default_nettype wire

// [hdl/dmr_mode_burst.v]
// Base mode register capture, field decode, DLL reset timing and burst beat sequencer
`timescale 1ns/100ps
`default_nettype none
`include "dmr_regs.vh"

module dmr_mode_burst (
   input wire clock,
   input wire nrst,
   input wire cke,
   input wire cs_n,
   input wire ras_n,
   input wire cas_n,
   input wire we_n,
   input wire [1:0] ba,
   input wire [12:0] addr,
   input wire beat_ready,
   output reg [`DMR_MODE_WIDTH-1:0] mode_register,
   output reg mode_valid,
   output reg mode_reserved_code,
   output reg burst_length_eight,
   output reg burst_order_type,
   output reg [2:0] read_latency_cycles,
   output reg [2:0] write_recovery_cycles,
   output reg powerdown_exit_select,
   output reg dll_reset_pulse,
   output reg dll_ready,
   output reg cmd_refused,
   output wire beat_valid,
   output wire beat_write,
   output wire [1:0] beat_bank,
   output wire [`DMR_COL_WIDTH-1:0] beat_column,
   output wire beat_last
);

   function bl_code_ok;
      input [2:0] code;
      begin
         bl_code_ok = (code == `DMR_BL_CODE_4) || (code == `DMR_BL_CODE_8);
      end
   endfunction

   function cl_code_ok;
      input [2:0] code;
      begin
         cl_code_ok = (code >= `DMR_CL_CODE_MIN) && (code <= `DMR_CL_CODE_MAX);
      end
   endfunction

   function wr_code_ok;
      input [2:0] code;
      begin
         wr_code_ok = (code >= `DMR_WR_CODE_MIN) && (code <= `DMR_WR_CODE_MAX);
      end
   endfunction

   // Low three column bits of one beat
   function [2:0] beat_low;
      input [2:0] start;
      input [2:0] idx;
      input bl8;
      input interleave;
      reg [1:0] nib;
      reg top;
      begin
         if (interleave)
            nib = start[1:0] ^ idx[1:0];
         else
            nib = start[1:0] + idx[1:0];
         if (bl8)
            top = start[2] ^ idx[2];
         else
            top = start[2];
         beat_low = {top, nib};
      end
   endfunction

   function is_last_beat;
      input [2:0] idx;
      input bl8;
      begin
         if (bl8)
            is_last_beat = (idx == `DMR_LAST_BEAT_8);
         else
            is_last_beat = (idx == `DMR_LAST_BEAT_4);
      end
   endfunction

   // Latency codes equal their cycle counts; reserved codes read as zero
   function [2:0] cl_cycles;
      input [2:0] code;
      begin
         if (cl_code_ok(code))
            cl_cycles = code;
         else
            cl_cycles = 3'h0;
      end
   endfunction

   // Recovery cycles run one above the code; reserved codes read as zero
   function [2:0] wr_cycles;
      input [2:0] code;
      begin
         if (wr_code_ok(code))
            wr_cycles = code + 3'h1;
         else
            wr_cycles = 3'h0;
      end
   endfunction

   // Any reserved code, or the test bit, keeps bursts refused until a clean value
   function code_reserved;
      input [`DMR_MODE_WIDTH-1:0] value;
      begin
         code_reserved = ~bl_code_ok(value[`DMR_BL_MSB:`DMR_BL_LSB])
                         | ~cl_code_ok(value[`DMR_CL_MSB:`DMR_CL_LSB])
                         | ~wr_code_ok(value[`DMR_WR_MSB:`DMR_WR_LSB])
                         | value[`DMR_TEST_BIT];
      end
   endfunction

   wire cmd_sel;
   wire [2:0] bl_field;
   wire [2:0] cl_field;
   wire [2:0] wr_field;
   wire field_reserved;
   wire cmd_mode_write;
   wire cmd_read;
   wire cmd_write;
   wire cmd_burst;
   wire buf_in_ready;
   wire [`DMR_BEAT_WIDTH-1:0] buf_in_data;
   wire [`DMR_BEAT_WIDTH-1:0] buf_out_data;

   reg seq_busy;
   reg seq_write;
   reg [1:0] seq_bank;
   reg [`DMR_COL_WIDTH-1:0] seq_col;
   reg [2:0] seq_idx;
   reg [7:0] dll_count;

   reg next_seq_busy;
   reg next_seq_write;
   reg [1:0] next_seq_bank;
   reg [`DMR_COL_WIDTH-1:0] next_seq_col;
   reg [2:0] next_seq_idx;
   reg take;
   reg advance;
   reg at_last;
   reg usable;
   reg [2:0] cur_low;
   reg interrupt;
   reg beat_end;

   // Commands count only with clock enable high and the chip selected
   assign cmd_sel = cke & ~cs_n;
   assign cmd_mode_write = cmd_sel & ~ras_n & ~cas_n & ~we_n
                           & (ba == `DMR_BANK_MODE);
   assign cmd_read = cmd_sel & ras_n & ~cas_n & we_n;
   assign cmd_write = cmd_sel & ras_n & ~cas_n & ~we_n;
   // The burst terminate pattern matches none of the decodes and falls through
   assign cmd_burst = cmd_read | cmd_write;

   // Field slices of the value on the address pins
   assign bl_field = addr[`DMR_BL_MSB:`DMR_BL_LSB];
   assign cl_field = addr[`DMR_CL_MSB:`DMR_CL_LSB];
   assign wr_field = addr[`DMR_WR_MSB:`DMR_WR_LSB];
   assign field_reserved = code_reserved(addr);

   // Mode register capture and field decode; extended writes are not stored here
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_register <= `DMR_MODE_RESET;
         mode_valid <= 1'b0;
         mode_reserved_code <= 1'b0;
         burst_length_eight <= 1'b0;
         burst_order_type <= 1'b0;
         read_latency_cycles <= 3'h0;
         write_recovery_cycles <= 3'h0;
         powerdown_exit_select <= 1'b0;
      end
      else if (cmd_mode_write)
      begin
         // Whole value replaced; rewrite allowed at any time in operation
         mode_register <= addr;
         mode_valid <= 1'b1;
         mode_reserved_code <= field_reserved;
         burst_length_eight <= (bl_field == `DMR_BL_CODE_8);
         burst_order_type <= addr[`DMR_ORDER_BIT];
         read_latency_cycles <= cl_cycles(cl_field);
         write_recovery_cycles <= wr_cycles(wr_field);
         powerdown_exit_select <= addr[`DMR_PD_EXIT_BIT];
      end
   end

   // DLL reset request and lock countdown; no path here reaches the array
   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         dll_reset_pulse <= 1'b0;
         dll_ready <= 1'b0;
         dll_count <= 8'h00;
      end
      else if (cmd_mode_write && addr[`DMR_DLL_RESET_BIT])
      begin
         dll_reset_pulse <= 1'b1;
         dll_ready <= 1'b0;
         dll_count <= `DMR_DLL_LOCK_CYCLES;
      end
      else
      begin
         dll_reset_pulse <= 1'b0;
         if (dll_count != 8'h00)
         begin
            dll_count <= dll_count - 8'h01;
            if (dll_count == 8'h01)
               dll_ready <= 1'b1;
         end
      end
   end

   // Burst sequencer: one beat word per cycle into the buffer
   always @*
   begin
      usable = mode_valid & ~mode_reserved_code;
      advance = seq_busy & buf_in_ready;
      at_last = is_last_beat(seq_idx, burst_length_eight);
      cur_low = beat_low(seq_col[2:0], seq_idx, burst_length_eight,
                         burst_order_type);
      // An eight-beat interrupt lands only as the current beat enters the buffer,
      // so a stalled receiver cannot lose the closing beat of the cut burst
      interrupt = burst_length_eight & (seq_write == cmd_write) & advance;
      take = 1'b0;
      if (cmd_burst && usable)
      begin
         if (!seq_busy)
            take = 1'b1;
         else if (advance && at_last)
            take = 1'b1;
         else if (interrupt)
            take = 1'b1;
         else
            take = 1'b0;
      end
      next_seq_busy = seq_busy;
      next_seq_write = seq_write;
      next_seq_bank = seq_bank;
      next_seq_col = seq_col;
      next_seq_idx = seq_idx;
      if (take)
      begin
         next_seq_busy = 1'b1;
         next_seq_write = cmd_write;
         next_seq_bank = ba;
         next_seq_col = addr[`DMR_COL_WIDTH-1:0];
         next_seq_idx = 3'h0;
      end
      else if (advance)
      begin
         if (at_last)
            next_seq_busy = 1'b0;
         else
            next_seq_idx = seq_idx + 3'h1;
      end
      // The beat entering with a newly taken command closes the old burst
      beat_end = at_last | (take & seq_busy);
   end

   always @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         seq_busy <= 1'b0;
         seq_write <= 1'b0;
         seq_bank <= 2'h0;
         seq_col <= {`DMR_COL_WIDTH{1'b0}};
         seq_idx <= 3'h0;
         cmd_refused <= 1'b0;
      end
      else
      begin
         seq_busy <= next_seq_busy;
         seq_write <= next_seq_write;
         seq_bank <= next_seq_bank;
         seq_col <= next_seq_col;
         seq_idx <= next_seq_idx;
         // Refusal is visible so a dropped command never goes unnoticed
         cmd_refused <= cmd_burst & ~take;
      end
   end

   // Beat word: write flag, bank, upper column, ordered low column, last flag
   assign buf_in_data = {seq_write, seq_bank, seq_col[`DMR_COL_WIDTH-1:3], cur_low, beat_end};

   // A stalled receiver freezes the sequencer instead of losing beats
   dmr_beat_buffer u_beat_buffer (
      .clock(clock),
      .nrst(nrst),
      .in_valid(seq_busy),
      .in_data(buf_in_data),
      .in_ready(buf_in_ready),
      .out_valid(beat_valid),
      .out_data(buf_out_data),
      .out_ready(beat_ready)
   );

   // Beat fields come straight from the buffer head flip-flops
   assign beat_write = buf_out_data[13];
   assign beat_bank = buf_out_data[12:11];
   assign beat_column = buf_out_data[10:1];
   assign beat_last = buf_out_data[0];

endmodule // dmr_mode_burst

`default_nettype wire

// [sim/dmr_mode_burst_properties.sv]
// Port checks on the mode register block
`timescale 1ns/100ps
`default_nettype none
module dmr_mode_burst_chk (
   input wire logic clock,
   input wire logic nrst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] ba,
   input wire logic [12:0] addr,
   input wire logic [12:0] mode_register,
   input wire logic mode_valid,
   input wire logic mode_reserved_code,
   input wire logic burst_length_eight,
   input wire logic burst_order_type,
   input wire logic [2:0] read_latency_cycles,
   input wire logic [2:0] write_recovery_cycles,
   input wire logic powerdown_exit_select,
   input wire logic dll_reset_pulse,
   input wire logic dll_ready,
   input wire logic cmd_refused
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sequence mw_s;
      cke && !cs_n && !ras_n && !cas_n && !we_n && ba == 2'h0;
   endsequence
   sequence term_s;
      cke && !cs_n && ras_n && cas_n && !we_n;
   endsequence
   mode_capture_a: assert property (mw_s |=> mode_valid && mode_register == $past(addr))
      else $error("mode value not captured");
   length_decode_a: assert property (mw_s ##0 addr[2:0] == 3'h3 |=> burst_length_eight)
      else $error("eight beat length not decoded");
   order_decode_a: assert property (mw_s |=> burst_order_type == $past(addr[3]))
      else $error("burst order wrong");
   latency_decode_a: assert property (mw_s ##0 addr[6:4] inside {[3:6]}
      |=> read_latency_cycles == $past(addr[6:4]))
      else $error("read latency wrong");
   recovery_decode_a: assert property (mw_s ##0 addr[11:9] inside {[1:5]}
      |=> write_recovery_cycles == $past(addr[11:9]) + 3'h1)
      else $error("write recovery wrong");
   exit_select_a: assert property (mw_s |=> powerdown_exit_select == $past(addr[12]))
      else $error("exit select wrong");
   dll_pulse_a: assert property (mw_s ##0 addr[8] |=> dll_reset_pulse ##1 !dll_reset_pulse)
      else $error("DLL reset pulse wrong");
   dll_hold_a: assert property ($rose(dll_reset_pulse) |-> !dll_ready [*8])
      else $error("DLL ready too early");
   terminate_quiet_a: assert property (term_s |=> !cmd_refused)
      else $error("terminate pattern answered");
   test_bit_a: assert property (mw_s ##0 addr[7] |=> mode_reserved_code)
      else $error("test bit not flagged");
endmodule // dmr_mode_burst_chk
bind dmr_mode_burst dmr_mode_burst_chk chk (.*);
`default_nettype wire

// [sim/dmr_ctl_model.sv]
// Memory controller model driving the command and address pins
`timescale 1ns/100ps
`default_nettype none
module dmr_ctl_model (
   input wire logic clock,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] ba,
   output logic [12:0] addr
);
   initial
   begin
      cke = 1'b1;
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = 3'h7;
      ba = 2'h0;
      addr = 13'h0000;
   end
   // One command, then deselect; calls land two cycles apart
   task issue(input logic [2:0] rcw, input logic [1:0] b, input logic [12:0] a);
      @(negedge clock);
      cs_n = 1'b0;
      {ras_n, cas_n, we_n} = rcw;
      ba = b;
      addr = a; // Whole value each time
      @(negedge clock);
      cs_n = 1'b1;
      {ras_n, cas_n, we_n} = 3'h7;
      // Deselected pins float, so never leave the old value showing
      ba = ~b;
      addr = ~a;
   endtask
   // Clock enable low makes the device ignore every command
   task set_clock_enable(input logic e);
      @(negedge clock);
      cke = e;
   endtask
endmodule // dmr_ctl_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the mode register and burst sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("[ERR] %0t %h %h", $time, a, b); end end
module tb;
   logic clock, nrst, beat_ready, stall;
   wire logic cke, cs_n, ras_n, cas_n, we_n, mode_valid, mode_reserved_code;
   wire logic burst_length_eight, burst_order_type, powerdown_exit_select;
   wire logic dll_reset_pulse, dll_ready, cmd_refused, beat_valid, beat_write, beat_last;
   wire logic [1:0] ba, beat_bank;
   wire logic [12:0] addr, mode_register;
   wire logic [2:0] read_latency_cycles, write_recovery_cycles;
   wire logic [9:0] beat_column;
   int failures = 0, checked = 0, cyc = 0, nref = 0;
   // Recovery time a controller would hold for this part; plain default
   localparam int wr_time_ns = 60;
   localparam int wr_cyc = (wr_time_ns + 24) / 25;
   logic [12:0] colq[$];
   logic lastq[$];
   int cycq[$];
   dmr_mode_burst dut (.*);
   dmr_ctl_model ctl (.*);
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cmd_refused === 1'b1)
         nref++;
      if (beat_valid === 1'b1 && beat_ready)
      begin
         colq.push_back({beat_write, beat_bank, beat_column});
         lastq.push_back(beat_last);
         cycq.push_back(cyc);
      end
      if (cyc == 6000)
      begin
         failures++;
         end_sim();
      end
   end
   // Receiver stalls every other pair of cycles when asked
   always @(negedge clock)
      beat_ready <= !(stall && cyc[1]);
   task end_sim;
      $display("failures=%0d checked=%0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task wait_beats(input int n);
      int k;
      k = 0;
      while (colq.size() < n && k < 200)
      begin
         @(negedge clock);
         k++;
      end
      repeat (4) @(negedge clock);
   endtask
   task t_reset;
      `CHK(mode_valid, 1'b0)
      ctl.issue(3'h5, 2'h0, 13'h0000);
      repeat (2) @(negedge clock);
      `CHK(nref, 1)
      `CHK(colq.size(), 0)
   endtask
   task t_dll;
      ctl.issue(3'h0, 2'h0, 13'h0332);
      repeat (199) @(negedge clock);
      `CHK(dll_ready, 1'b0)
      @(negedge clock);
      `CHK(dll_ready, 1'b1)
   endtask
   task t_fields;
      logic [12:0] v;
      for (int i = 0; i < 5; i++)
      begin
         v = {i[0], 3'(i + 1), 2'h0, 3'(3 + i % 4), i[1], 3'h3};
         ctl.issue(3'h0, 2'h0, v);
         `CHK(mode_register, v)
         `CHK(read_latency_cycles, 3'(3 + i % 4))
         `CHK(write_recovery_cycles, 3'(i + 2))
         `CHK(powerdown_exit_select, v[12])
         `CHK(burst_order_type, v[3])
         `CHK({burst_length_eight, mode_reserved_code}, 2'h2)
      end
      ctl.issue(3'h0, 2'h0, {1'b0, 3'(wr_cyc - 1), 9'h033});
      `CHK(write_recovery_cycles, 3'(wr_cyc))
      ctl.issue(3'h0, 2'h0, 13'h0032);
      `CHK(mode_reserved_code, 1'b1)
      ctl.issue(3'h5, 2'h0, 13'h0000);
      ctl.issue(3'h0, 2'h0, 13'h02B2);
      `CHK(mode_reserved_code, 1'b1)
      ctl.issue(3'h0, 2'h0, 13'h0232);
      ctl.issue(3'h0, 2'h1, 13'h1FFF);
      `CHK(mode_register, 13'h0232)
      ctl.set_clock_enable(1'b0);
      ctl.issue(3'h0, 2'h0, 13'h0233);
      `CHK(mode_register, 13'h0232)
      ctl.set_clock_enable(1'b1);
      ctl.issue(3'h6, 2'h0, 13'h0000);
      @(negedge clock);
      `CHK(nref, 2)
   endtask
   task burst(input logic [2:0] rcw, input logic [12:0] m, input logic [9:0] col,
      input logic [23:0] ex, input int n);
      ctl.issue(3'h0, 2'h0, m);
      colq.delete();
      lastq.delete();
      ctl.issue(rcw, 2'h1, {3'h0, col});
      wait_beats(n);
      `CHK(colq.size(), n)
      for (int i = 0; i < n; i++)
      begin
         `CHK(colq[i], {!rcw[0], 2'h1, col[9:3], ex[23 - 3 * i -: 3]})
         `CHK(lastq[i], i == n - 1)
      end
   endtask
   task t_seq(input logic [12:0] m, input logic [2:0] rcw, input int n, input int r);
      int n0;
      ctl.issue(3'h0, 2'h0, m);
      colq.delete();
      lastq.delete();
      cycq.delete();
      n0 = nref;
      ctl.issue(3'h5, 2'h0, 13'h0000);
      repeat (r) @(negedge clock);
      ctl.issue(rcw, 2'h0, 13'h0004);
      wait_beats(n);
      `CHK(nref - n0, int'(r != 2 && (rcw != 3'h5 || m[0] == 1'b0)))
      `CHK(lastq[$], 1'b1)
      if (r == 0 && rcw == 3'h5 && m[0])
      begin
         `CHK(colq.size(), 10)
         `CHK(lastq[1], 1'b1)
      end
      if (r == 2)
         `CHK(cycq[7] - cycq[0], 7)
   endtask
   initial
   begin
      nrst = 1'b0;
      stall = 1'b0;
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      t_reset();
      t_dll();
      t_fields();
      stall = 1'b1;
      burst(3'h5, 13'h0233, 10'h3A5, 24'hBBC298, 8);
      stall = 1'b0;
      burst(3'h4, 13'h023B, 10'h3A5, 24'hB3E21A, 8);
      burst(3'h5, 13'h0232, 10'h001, 24'h298000, 4);
      burst(3'h4, 13'h023A, 10'h003, 24'h688000, 4);
      burst(3'h5, 13'h0233, 10'h007, 24'hF2E60A, 8);
      t_seq(13'h0232, 3'h5, 8, 2);
      t_seq(13'h0232, 3'h5, 4, 0);
      t_seq(13'h0233, 3'h5, 8, 0);
      t_seq(13'h0233, 3'h4, 8, 0);
      end_sim();
   end
endmodule // tb
`default_nettype wire
